/* logic/prst_pkg.sv */
/*
  Constants and types for the processor reset interface.
  Assumes a single 40 MHz clock; all users import the whole package.
*/
package prst_pkg;
  localparam int unsigned PRST_CLK_MHZ = 40;
  // Least hold of an external reset input, in clock cycles
  localparam int unsigned PRST_MIN_HOLD = 8;
  // Power-on reset stretch, in clock cycles
  localparam int unsigned PRST_POR_CYCLES = 16;
  // Request stays up this many cycles after the matching input
  localparam int unsigned PRST_REQ_TAIL = 2;
  localparam int unsigned PRST_CNT_W = 5;
  localparam logic [1:0] PRST_TYPE_NONE = 2'h0;
  localparam logic [1:0] PRST_TYPE_CORE = 2'h1;
  localparam logic [1:0] PRST_TYPE_CHIP = 2'h2;
  localparam logic [1:0] PRST_TYPE_SYS = 2'h3;
  localparam logic [1:0] PRST_MRR_RST = 2'h0;
  localparam logic [PRST_CNT_W-1:0] PRST_CNT_ZERO = 5'h00;
  localparam logic [PRST_CNT_W-1:0] PRST_CNT_ONE = 5'h01;
  localparam logic [1:0] PRST_TAIL_ZERO = 2'h0;
  localparam logic [1:0] PRST_TAIL_ONE = 2'h1;

  typedef enum logic [1:0] {
    PRST_REQ_IDLE,
    PRST_REQ_WAIT,
    PRST_REQ_TAILING
  } prst_req_e;

  // Reset type implied by the three input levels
  function automatic logic [1:0] prst_decode(input logic core,
      input logic chip, input logic sys);
    if (!core)
      return PRST_TYPE_NONE;
    else if (chip && sys)
      return PRST_TYPE_SYS;
    else if (chip)
      return PRST_TYPE_CHIP;
    else
      return PRST_TYPE_CORE;
  endfunction
endpackage

/* logic/prst_por.sv */
/*
  Power-on reset generator: holds all internal reset levels for a fixed
  number of cycles after the first clock edges.
  Assumes RST_I is pulsed once at start so the counter begins at zero.
*/
`timescale 1ns/10ps
module prst_por
  import prst_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  output logic por_o
);
  logic [PRST_CNT_W-1:0] cnt_q;

  // Restart on the system reset line so a simulation can start cleanly
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt_q <= PRST_CNT_ZERO;
    else if (cnt_q != PRST_CNT_W'(PRST_POR_CYCLES))
      cnt_q <= cnt_q + PRST_CNT_ONE;
  end

  assign por_o = (cnt_q != PRST_CNT_W'(PRST_POR_CYCLES));

  a_por_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(por_o) |-> $past(cnt_q) == PRST_CNT_W'(PRST_POR_CYCLES - 1))
    else $error("power-on stretch length wrong");
endmodule

/* logic/prst_req.sv */
/*
  One reset-request channel: latches a request, then holds it until
  two cycles after the matching reset input is seen.
  Assumes request pulses and reset input are synchronous to clk_i.
*/
`timescale 1ns/10ps
module prst_req
  import prst_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic raise_i,
  input wire logic reset_in_i,
  output logic req_o
);
  prst_req_e state_q;
  logic [1:0] tail_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PRST_REQ_IDLE;
      tail_q <= PRST_TAIL_ZERO;
    end else begin
      case (state_q)
        PRST_REQ_IDLE: begin
          if (raise_i)
            state_q <= PRST_REQ_WAIT;
        end
        PRST_REQ_WAIT: begin
          if (reset_in_i) begin
            state_q <= PRST_REQ_TAILING;
            tail_q <= PRST_TAIL_ONE;
          end
        end
        PRST_REQ_TAILING: begin
          if (tail_q == 2'(PRST_REQ_TAIL))
            state_q <= PRST_REQ_IDLE;
          else
            tail_q <= tail_q + PRST_TAIL_ONE;
        end
        default: state_q <= PRST_REQ_IDLE;
      endcase
    end
  end

  assign req_o = (state_q != PRST_REQ_IDLE);

  sequence s_granted;
    req_o && reset_in_i && state_q == PRST_REQ_WAIT;
  endsequence
  a_req_tail: assert property (@(posedge clk_i) disable iff (rst_i)
    s_granted |=> req_o ##1 req_o ##1 !req_o)
    else $error("request not dropped two cycles after input");
  a_req_held: assert property (@(posedge clk_i) disable iff (rst_i)
    req_o && state_q == PRST_REQ_WAIT && !reset_in_i |=> req_o)
    else $error("request dropped before reset input");
endmodule

/* logic/prst_top.sv */
/*
  Processor reset interface: request outputs, power-on generation,
  reset-type recording and the derived internal reset levels.
  Assumes external reset logic drives the inputs synchronously to CLK_I.
*/
`timescale 1ns/10ps
// Functional notes
// - Combinations: core, +chip, +system, +test reset
// - Record 01 core, 10 chip, 11 system
// - Power-on asserts all four sixteen cycles
// - Request holds two cycles past matching input
// - Debug field or watchdog raises typed request
// - Requests alone reset nothing
// - Core input resets core, caches, controllers
// - Core input low: no reset, no record (system input still resets test-access unit)
// - Chip input only records chip type
// - System input resets test-access unit only
// - Active-low test reset resets all logic
module prst_top
  import prst_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic DEBUG_RESET_WR_I,
  input wire logic [1:0] DEBUG_RESET_FIELD_I,
  input wire logic WATCHDOG_RESET_STATE_I,
  input wire logic [1:0] WATCHDOG_RESET_CONTROL_I,
  input wire logic CORE_RESET_IN_I,
  input wire logic CHIP_RESET_IN_I,
  input wire logic SYSTEM_RESET_IN_I,
  input wire logic TEST_RESET_N_IN_I,
  output logic CORE_RESET_REQUEST_OUT_O,
  output logic CHIP_RESET_REQUEST_OUT_O,
  output logic SYSTEM_RESET_REQUEST_OUT_O,
  output logic [1:0] MOST_RECENT_RESET_FIELD_O,
  output logic CORE_LOGIC_RESET_O,
  output logic TEST_UNIT_RESET_O,
  output logic POR_ACTIVE_O
);
  logic por;
  logic core_eff, chip_eff, sys_eff, test_eff;
  logic [1:0] req_type;
  logic [1:0] in_type;
  logic [1:0] mrr_q;
  logic [1:0] pend_q;
  logic [2:0] raise;
  logic [2:0] req;
  logic core_rst_q, test_rst_q;

  prst_por u_por (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .por_o(por)
  );

  // Internal power-on drives all four levels together
  assign core_eff = CORE_RESET_IN_I | por;
  assign chip_eff = CHIP_RESET_IN_I | por;
  assign sys_eff = SYSTEM_RESET_IN_I | por;
  assign test_eff = !TEST_RESET_N_IN_I | por;

  // Debug write takes priority over a simultaneous watchdog event
  always_comb begin
    if (DEBUG_RESET_WR_I)
      req_type = DEBUG_RESET_FIELD_I;
    else if (WATCHDOG_RESET_STATE_I)
      req_type = WATCHDOG_RESET_CONTROL_I;
    else
      req_type = PRST_TYPE_NONE;
  end

  assign raise[0] = (req_type == PRST_TYPE_CORE);
  assign raise[1] = (req_type == PRST_TYPE_CHIP);
  assign raise[2] = (req_type == PRST_TYPE_SYS);

  prst_req u_req_core (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .raise_i(raise[0]),
    .reset_in_i(CORE_RESET_IN_I),
    .req_o(req[0])
  );
  prst_req u_req_chip (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .raise_i(raise[1]),
    .reset_in_i(CHIP_RESET_IN_I),
    .req_o(req[1])
  );
  prst_req u_req_sys (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .raise_i(raise[2]),
    .reset_in_i(SYSTEM_RESET_IN_I),
    .req_o(req[2])
  );

  // Requests only signal outward; nothing here is reset by them
  assign CORE_RESET_REQUEST_OUT_O = req[0];
  assign CHIP_RESET_REQUEST_OUT_O = req[1];
  assign SYSTEM_RESET_REQUEST_OUT_O = req[2];

  // Type is taken from the pattern seen while core reset is held;
  // the field is written when core reset releases, i.e. after reset.
  assign in_type = prst_decode(core_eff, chip_eff, sys_eff);

  always_ff @(posedge CLK_I) begin
    if (RST_I)
      pend_q <= PRST_TYPE_NONE;
    else if (core_eff && in_type > pend_q)
      pend_q <= in_type;
    else if (!core_eff)
      pend_q <= PRST_TYPE_NONE;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I)
      mrr_q <= PRST_MRR_RST;
    else if (!core_eff && pend_q != PRST_TYPE_NONE)
      mrr_q <= pend_q;
  end
  assign MOST_RECENT_RESET_FIELD_O = mrr_q;

  // Registered internal reset levels for core and test-access unit
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      core_rst_q <= 1'b1;
      test_rst_q <= 1'b1;
    end else begin
      core_rst_q <= core_eff | test_eff;
      test_rst_q <= sys_eff | test_eff;
    end
  end
  assign CORE_LOGIC_RESET_O = core_rst_q;
  assign TEST_UNIT_RESET_O = test_rst_q;
  assign POR_ACTIVE_O = por;

  a_core_rec: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(core_eff) && pend_q == PRST_TYPE_CORE
    |=> mrr_q == PRST_TYPE_CORE)
    else $error("core reset not recorded as core");
  a_chip_rec: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(core_eff) && pend_q == PRST_TYPE_CHIP
    |=> mrr_q == PRST_TYPE_CHIP)
    else $error("chip reset not recorded as chip");
  a_sys_rec: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(core_eff) && pend_q == PRST_TYPE_SYS
    |=> mrr_q == PRST_TYPE_SYS)
    else $error("system reset not recorded");
  a_no_rec: assert property (@(posedge CLK_I) disable iff (RST_I)
    !core_eff && !$past(core_eff) |=> $stable(mrr_q))
    else $error("field changed without core reset");
  a_core_logic: assert property (@(posedge CLK_I) disable iff (RST_I)
    core_eff |=> CORE_LOGIC_RESET_O)
    else $error("core input did not reset core logic");
  a_test_unit: assert property (@(posedge CLK_I) disable iff (RST_I)
    !core_eff && !test_eff |=> TEST_UNIT_RESET_O == $past(sys_eff))
    else $error("test unit reset not tied to system input");
  a_trst_all: assert property (@(posedge CLK_I) disable iff (RST_I)
    test_eff |=> CORE_LOGIC_RESET_O && TEST_UNIT_RESET_O)
    else $error("test reset did not reset all logic");
  a_por_all: assert property (@(posedge CLK_I) disable iff (RST_I)
    por |-> core_eff && chip_eff && sys_eff && test_eff)
    else $error("power-on did not assert all levels");
  a_raise_req: assert property (@(posedge CLK_I) disable iff (RST_I)
    DEBUG_RESET_WR_I && DEBUG_RESET_FIELD_I == PRST_TYPE_CHIP
    |=> CHIP_RESET_REQUEST_OUT_O)
    else $error("debug write did not raise chip request");
  a_req_inert: assert property (@(posedge CLK_I) disable iff (RST_I)
    !por && !CORE_RESET_IN_I && TEST_RESET_N_IN_I ##1 !por
    |-> !CORE_LOGIC_RESET_O)
    else $error("request alone caused reset");

  // Request sources seen at the pins; a busy channel absorbs a new
  // raise, so only idle channels are expected to answer.
  sequence s_dbg_core;
    DEBUG_RESET_WR_I && DEBUG_RESET_FIELD_I == PRST_TYPE_CORE &&
    !CORE_RESET_REQUEST_OUT_O;
  endsequence
  sequence s_dbg_sys;
    DEBUG_RESET_WR_I && DEBUG_RESET_FIELD_I == PRST_TYPE_SYS &&
    !SYSTEM_RESET_REQUEST_OUT_O;
  endsequence
  sequence s_wd_core;
    !DEBUG_RESET_WR_I && WATCHDOG_RESET_STATE_I &&
    WATCHDOG_RESET_CONTROL_I == PRST_TYPE_CORE &&
    !CORE_RESET_REQUEST_OUT_O;
  endsequence
  sequence s_wd_chip;
    !DEBUG_RESET_WR_I && WATCHDOG_RESET_STATE_I &&
    WATCHDOG_RESET_CONTROL_I == PRST_TYPE_CHIP &&
    !CHIP_RESET_REQUEST_OUT_O;
  endsequence
  sequence s_wd_sys;
    !DEBUG_RESET_WR_I && WATCHDOG_RESET_STATE_I &&
    WATCHDOG_RESET_CONTROL_I == PRST_TYPE_SYS &&
    !SYSTEM_RESET_REQUEST_OUT_O;
  endsequence

  a_dbg_core: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_dbg_core |=> CORE_RESET_REQUEST_OUT_O)
    else $error("debug write did not raise core request");
  a_dbg_sys: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_dbg_sys |=> SYSTEM_RESET_REQUEST_OUT_O)
    else $error("debug write did not raise system request");
  a_wd_core: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_wd_core |=> CORE_RESET_REQUEST_OUT_O)
    else $error("watchdog did not raise core request");
  a_wd_chip: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_wd_chip |=> CHIP_RESET_REQUEST_OUT_O)
    else $error("watchdog did not raise chip request");
  a_wd_sys: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_wd_sys |=> SYSTEM_RESET_REQUEST_OUT_O)
    else $error("watchdog did not raise system request");
  a_dbg_wins: assert property (@(posedge CLK_I) disable iff (RST_I)
    DEBUG_RESET_WR_I && DEBUG_RESET_FIELD_I == PRST_TYPE_NONE &&
    req == 3'h0 |=> req == 3'h0)
    else $error("request raised by a debug write of none");
  a_no_raise: assert property (@(posedge CLK_I) disable iff (RST_I)
    !DEBUG_RESET_WR_I && !WATCHDOG_RESET_STATE_I && req == 3'h0
    |=> req == 3'h0)
    else $error("request raised with no source");

  // A request falls exactly three edges after its input was seen
  a_core_fall: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(CORE_RESET_REQUEST_OUT_O) |-> $past(CORE_RESET_IN_I, 3))
    else $error("core request fell without input");
  a_chip_fall: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(CHIP_RESET_REQUEST_OUT_O) |-> $past(CHIP_RESET_IN_I, 3))
    else $error("chip request fell without input");
  a_sys_fall: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(SYSTEM_RESET_REQUEST_OUT_O) |-> $past(SYSTEM_RESET_IN_I, 3))
    else $error("system request fell without input");

  // Input patterns held by the far side, outside the power-on stretch
  sequence s_quiet;
    !CORE_RESET_IN_I && !por;
  endsequence
  sequence s_core_pat;
    CORE_RESET_IN_I && !CHIP_RESET_IN_I && !SYSTEM_RESET_IN_I &&
    TEST_RESET_N_IN_I && !por;
  endsequence
  sequence s_chip_pat;
    CORE_RESET_IN_I && CHIP_RESET_IN_I && !SYSTEM_RESET_IN_I &&
    TEST_RESET_N_IN_I && !por;
  endsequence
  sequence s_sys_pat;
    CORE_RESET_IN_I && CHIP_RESET_IN_I && SYSTEM_RESET_IN_I &&
    TEST_RESET_N_IN_I && !por;
  endsequence
  sequence s_por_pat;
    CORE_RESET_IN_I && CHIP_RESET_IN_I && SYSTEM_RESET_IN_I &&
    !TEST_RESET_N_IN_I && !por;
  endsequence

  a_pin_core: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_quiet ##1 s_core_pat [*8] ##1 s_quiet
    |=> MOST_RECENT_RESET_FIELD_O == PRST_TYPE_CORE)
    else $error("core pattern not recorded as core");
  a_pin_chip: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_quiet ##1 s_chip_pat [*8] ##1 s_quiet
    |=> MOST_RECENT_RESET_FIELD_O == PRST_TYPE_CHIP)
    else $error("chip pattern not recorded as chip");
  a_pin_sys: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_quiet ##1 s_sys_pat [*8] ##1 s_quiet
    |=> MOST_RECENT_RESET_FIELD_O == PRST_TYPE_SYS)
    else $error("system pattern not recorded as system");
  a_pin_por: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_quiet ##1 s_por_pat [*8] ##1 s_quiet
    |=> MOST_RECENT_RESET_FIELD_O == PRST_TYPE_SYS)
    else $error("power-on pattern not recorded as system");
  a_mrr_hold: assert property (@(posedge CLK_I) disable iff (RST_I)
    s_quiet ##1 s_quiet |=> $stable(MOST_RECENT_RESET_FIELD_O))
    else $error("field moved while core input low");
  a_core_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
    !CORE_RESET_IN_I && TEST_RESET_N_IN_I && !por
    |=> !CORE_LOGIC_RESET_O)
    else $error("core logic reset without core input");
  a_unit_idle: assert property (@(posedge CLK_I) disable iff (RST_I)
    !SYSTEM_RESET_IN_I && TEST_RESET_N_IN_I && !por
    |=> !TEST_UNIT_RESET_O)
    else $error("test unit reset without system input");
  a_sys_unit: assert property (@(posedge CLK_I) disable iff (RST_I)
    SYSTEM_RESET_IN_I |=> TEST_UNIT_RESET_O)
    else $error("system input did not reset test unit");
  a_trst_pin: assert property (@(posedge CLK_I) disable iff (RST_I)
    !TEST_RESET_N_IN_I |=> CORE_LOGIC_RESET_O && TEST_UNIT_RESET_O)
    else $error("test reset pin did not reset all logic");
  a_por_pin: assert property (@(posedge CLK_I) disable iff (RST_I)
    POR_ACTIVE_O |=> CORE_LOGIC_RESET_O && TEST_UNIT_RESET_O)
    else $error("power-on did not reset all logic");

  // Length of the current power-on stretch, counted apart from the
  // generator so a fault in its counter cannot hide itself
  logic [PRST_CNT_W-1:0] por_len_q;

  always_ff @(posedge CLK_I) begin
    if (RST_I || !por)
      por_len_q <= PRST_CNT_ZERO;
    else if (por_len_q != PRST_CNT_W'(PRST_POR_CYCLES))
      por_len_q <= por_len_q + PRST_CNT_ONE;
  end

  a_por_min: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(POR_ACTIVE_O) |-> por_len_q == PRST_CNT_W'(PRST_POR_CYCLES))
    else $error("power-on stretch shorter than required");
endmodule

/* tb/prst_ext_rst.sv */
/*
  Model of the external reset logic that answers the request outputs.
  Assumes the design samples its reset inputs on the rising clock edge.
*/
`timescale 1ns/10ps
module prst_ext_rst
  import prst_pkg::*;
#(
  parameter int DELAY = 4
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic core_req_i,
  input wire logic chip_req_i,
  input wire logic sys_req_i,
  input wire logic ovr_en_i,
  input wire logic [3:0] ovr_val_i,
  output logic core_o,
  output logic chip_o,
  output logic sys_o,
  output logic trst_n_o
);
  logic [4:0] cnt_q;
  logic [2:0] lvl_q;
  // Falling edge keeps every level settled at the sampling edge
  always_ff @(negedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 5'h00;
      lvl_q <= 3'h0;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
      // Types kept apart; chip and system always carry core
      if (cnt_q == 5'h09)
        lvl_q <= sys_req_i ? 3'h7 : (chip_req_i ? 3'h3 : 3'h1);
      // Level lives for counts 8..1
      if (cnt_q == 5'h01)
        lvl_q <= 3'h0;
    end else if (core_req_i || chip_req_i || sys_req_i) begin
      cnt_q <= 5'(DELAY + PRST_MIN_HOLD + 1);
    end
  end
  // Only table patterns unless the bench overrides on purpose
  assign core_o = ovr_en_i ? ovr_val_i[0] : lvl_q[0];
  assign chip_o = ovr_en_i ? ovr_val_i[1] : lvl_q[1];
  assign sys_o = ovr_en_i ? ovr_val_i[2] : lvl_q[2];
  assign trst_n_o = ovr_en_i ? ovr_val_i[3] : 1'b1;
endmodule

/* tb/tb_top.sv */
/*
  Testbench for the reset interface: request sources and forced patterns.
  Assumes prst_ext_rst answers each request after a short delay.
*/
`timescale 1ns/10ps
module tb_top;
  import prst_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dbg_wr = 1'b0;
  logic wd_st = 1'b0;
  logic [1:0] dbg_fld = 2'h0;
  logic [1:0] wd_ctl = 2'h0;
  logic ovr_en = 1'b0;
  logic [3:0] ovr_val = 4'hF;
  logic core_in, chip_in, sys_in, trst_n, lrst, trst_u, por;
  logic [1:0] fld;
  logic [2:0] req, ins;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  assign ins = {sys_in, chip_in, core_in};
  prst_top prst_top_inst (.CLK_I(clk), .RST_I(rst), .DEBUG_RESET_WR_I(dbg_wr),
    .DEBUG_RESET_FIELD_I(dbg_fld), .WATCHDOG_RESET_STATE_I(wd_st),
    .WATCHDOG_RESET_CONTROL_I(wd_ctl), .CORE_RESET_IN_I(core_in),
    .CHIP_RESET_IN_I(chip_in), .SYSTEM_RESET_IN_I(sys_in),
    .TEST_RESET_N_IN_I(trst_n), .CORE_RESET_REQUEST_OUT_O(req[0]),
    .CHIP_RESET_REQUEST_OUT_O(req[1]), .SYSTEM_RESET_REQUEST_OUT_O(req[2]),
    .MOST_RECENT_RESET_FIELD_O(fld), .CORE_LOGIC_RESET_O(lrst),
    .TEST_UNIT_RESET_O(trst_u), .POR_ACTIVE_O(por));
  prst_ext_rst #(.DELAY(4)) prst_ext_rst_inst (.clk_i(clk), .rst_i(rst),
    .core_req_i(req[0]), .chip_req_i(req[1]), .sys_req_i(req[2]),
    .ovr_en_i(ovr_en), .ovr_val_i(ovr_val), .core_o(core_in),
    .chip_o(chip_in), .sys_o(sys_in), .trst_n_o(trst_n));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [2:0] seen, input logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %b exp %b", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("counts: %0d compares, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic raise(input logic src, input logic [1:0] t);
    tick(1);
    if (src) begin
      wd_st = 1'b1;
      wd_ctl = t;
    end else begin
      dbg_wr = 1'b1;
      dbg_fld = t;
    end
    tick(1);
    dbg_wr = 1'b0;
    wd_st = 1'b0;
  endtask
  task automatic run_req(input logic src, input logic [1:0] t);
    int hi;
    logic tu, lr;
    hi = 0;
    tu = 1'b0;
    lr = 1'b0;
    raise(src, t);
    check(req, 3'h1 << (t - 2'h1));
    check({2'h0, lrst}, 3'h0);
    repeat (40) begin
      tick(1);
      if (ins[t-2'h1] && req[t-2'h1])
        hi++;
      tu |= trst_u;
      lr |= lrst;
    end
    check(3'(hi), 3'(PRST_REQ_TAIL));
    check({2'h0, tu}, {2'h0, t == 2'h3});
    check({2'h0, lr}, 3'h1);
    check({1'b0, fld}, {1'b0, t});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Whole run needs about 300 cycles
    if (cyc == 2000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    int n;
    n = 0;
    tick(2);
    rst = 1'b0;
    do begin
      tick(1);
      n++;
      if (por === 1'b1)
        check({1'b0, lrst, trst_u}, 3'h3);
    end while (por === 1'b1 && n < 40);
    check({2'h0, n >= PRST_POR_CYCLES}, 3'h1);
    tick(3);
    check({1'b0, fld}, {1'b0, PRST_TYPE_SYS});
    $display("test power-on done");
    for (int s = 0; s < 2; s++) begin
      for (int t = 3; t > 0; t--)
        run_req(s[0], t[1:0]);
    end
    $display("test requests done");
    raise(1'b0, 2'h0);
    raise(1'b1, 2'h0);
    tick(2);
    check(req, 3'h0);
    ovr_val = 4'hE;
    ovr_en = 1'b1;
    tick(8);
    check({2'h0, lrst}, 3'h0);
    ovr_en = 1'b0;
    tick(4);
    check({1'b0, fld}, {1'b0, PRST_TYPE_CORE});
    // Test reset pattern carries system input too
    ovr_val = 4'h7;
    ovr_en = 1'b1;
    tick(8);
    check({1'b0, lrst, trst_u}, 3'h3);
    ovr_en = 1'b0;
    tick(4);
    check({1'b0, fld}, {1'b0, PRST_TYPE_SYS});
    $display("test forced patterns done");
    finish_test();
  end
endmodule
